// ---- common/vcf_pkg.sv ----
// package of constants and types for the voltage output filter select block
package vcf_pkg;
    // register addresses on the internal register port
    localparam logic [7:0] ADDR_SRC_SEL  = 8'h46;  // output source select
    localparam logic [7:0] ADDR_FLT_CTL  = 8'h47;  // final filter control
    localparam logic [7:0] ADDR_RO_LO    = 8'h19;  // start of read-only range
    localparam logic [7:0] ADDR_RO_HI    = 8'h2C;  // end of read-only range
    // reset values
    localparam logic [7:0] RST_SRC_SEL   = 8'h04;
    localparam logic [7:0] RST_FLT_CTL   = 8'h00;
    // field positions
    localparam int         POS_IRQ_MASK  = 4;
    localparam int         POS_SRC_LO    = 2;
    localparam int         POS_FLT_SEL   = 7;
    localparam int         POS_AVG_LO    = 3;
    // writable bit masks, all other bits reserved
    localparam logic [7:0] WMASK_SRC_SEL = 8'h1C;
    localparam logic [7:0] WMASK_FLT_CTL = 8'hF8;
    // output source encodings
    localparam logic [1:0] SRC_FINAL     = 2'h0;
    localparam logic [1:0] SRC_CIC2      = 2'h1;
    localparam logic [1:0] SRC_DECHOP    = 2'h2;
    localparam logic [1:0] SRC_CIC1      = 2'h3;
    // averaging count encodings
    localparam logic [3:0] AVG_BYPASS    = 4'h0;
    localparam logic [3:0] AVG_1         = 4'h1;
    localparam logic [3:0] AVG_3         = 4'h3;
    localparam logic [3:0] AVG_7         = 4'h7;
    localparam logic [3:0] AVG_15        = 4'hF;

    // register access request from the serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vcf_req_t;

    // one sample word from each filter stage
    typedef struct packed {
        logic [15:0] fir;
        logic [15:0] cic2;
        logic [15:0] dechop;
        logic [15:0] cic1;
    } vcf_taps_t;
endpackage

// ---- rtl/vcf_fifo.sv ----
// small flop-based fifo with valid and ready on both sides
module vcf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];     // storage flops
    logic [AW-1:0]    wrPtr_r;           // write index
    logic [AW-1:0]    rdPtr_r;           // read index
    logic [AW:0]      count_r;           // fill level
    logic             push;              // accepted write
    logic             pop;               // accepted read

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    // pointers and level
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- rtl/vcf_select.sv ----
// voltage channel output source, final filter and interrupt mask control
module vcf_select #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire vcf_pkg::vcf_req_t   regReq,
    output logic [7:0]               regRdata_r,
    output logic                     regRvalid_r,
    input  wire vcf_pkg::vcf_taps_t  taps,
    input  wire logic                tapValid,
    input  wire logic                dataReady,
    output logic                     dataIrq_r,
    output logic [WIDTH-1:0]         outWord_r,
    output logic                     outValid_r,
    input  wire logic                outReady,
    output logic                     tapReady_r
);
    import vcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and internal signals
    logic [7:0]       srcSel_r;          // output source select
    logic [7:0]       fltCtl_r;          // final filter control
    logic [15:0]      avgOut_r;          // moving average result
    logic [19:0]      accum_r;           // averaging accumulator
    logic [3:0]       avgCnt_r;          // samples in accumulator
    logic [15:0]      finalWord;         // fir or averaged word
    logic [WIDTH-1:0] selWord;           // chosen source word
    logic             fifoInReady;       // fifo space
    logic             fifoOutValid;      // fifo has data
    logic [WIDTH-1:0] fifoOutData;       // fifo head
    logic             fltMa;             // moving average selected
    logic [3:0]       avgSel;            // averaging count field
    logic [1:0]       srcField;          // source field
    logic             inRo;              // address in read-only range

    assign fltMa    = fltCtl_r[POS_FLT_SEL];
    assign avgSel   = fltCtl_r[POS_AVG_LO +: 4];
    assign srcField = srcSel_r[POS_SRC_LO +: 2];
    assign inRo     = (regReq.addr >= ADDR_RO_LO) && (regReq.addr <= ADDR_RO_HI);

    ////////////////////////////////////////////////////////////////////////
    // register writes, reserved bits masked off
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            srcSel_r <= RST_SRC_SEL;
            fltCtl_r <= RST_FLT_CTL;
        end else if (regReq.wr && !inRo) begin
            if (regReq.addr == ADDR_SRC_SEL) begin
                srcSel_r <= regReq.wdata & WMASK_SRC_SEL;
            end else if (regReq.addr == ADDR_FLT_CTL) begin
                fltCtl_r <= regReq.wdata & WMASK_FLT_CTL;
            end
        end
    end

    // register reads, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdata_r  <= 8'h00;
            regRvalid_r <= 1'b0;
        end else begin
            regRvalid_r <= regReq.rd;
            if (!regReq.rd) begin
                regRdata_r <= regRdata_r;
            end else if (regReq.addr == ADDR_SRC_SEL) begin
                regRdata_r <= srcSel_r;
            end else if (regReq.addr == ADDR_FLT_CTL) begin
                regRdata_r <= fltCtl_r;
            end else begin
                regRdata_r <= 8'h00;                        // unmapped reads zero
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt gating
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dataIrq_r <= 1'b0;
        end else begin
            dataIrq_r <= dataReady && !srcSel_r[POS_IRQ_MASK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // moving average: sums count-field fir samples, then divides by the count
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            accum_r  <= '0;
            avgCnt_r <= '0;
            avgOut_r <= '0;
        end else if (tapValid && fifoInReady) begin
            if (avgSel == AVG_BYPASS) begin
                avgOut_r <= taps.fir;
                accum_r  <= '0;
                avgCnt_r <= '0;
            end else if (avgCnt_r + 4'h1 >= avgSel) begin
                // divide by count; 1,3,7,15 handled as true division
                avgOut_r <= 16'((accum_r + 20'(taps.fir)) / 20'(avgSel));
                accum_r  <= '0;
                avgCnt_r <= '0;
            end else begin
                accum_r  <= accum_r + 20'(taps.fir);
                avgCnt_r <= avgCnt_r + 4'h1;
            end
        end
    end

    assign finalWord = fltMa ? avgOut_r : taps.fir;

    ////////////////////////////////////////////////////////////////////////
    // source select
    always_comb begin
        case (srcField)
            SRC_FINAL:  selWord = WIDTH'(finalWord);
            SRC_CIC2:   selWord = WIDTH'(taps.cic2);
            SRC_DECHOP: selWord = WIDTH'(taps.dechop);
            default:    selWord = WIDTH'(taps.cic1);
        endcase
    end

    vcf_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .inValid  (tapValid),
        .inReady  (fifoInReady),
        .inData   (selWord),
        .outValid (fifoOutValid),
        .outReady (!outValid_r || outReady),
        .outData  (fifoOutData)
    );

    // output stage register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            outWord_r  <= '0;
            outValid_r <= 1'b0;
            tapReady_r <= 1'b0;
        end else begin
            tapReady_r <= fifoInReady;
            if (!outValid_r || outReady) begin
                outValid_r <= fifoOutValid;
                outWord_r  <= fifoOutData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_irq_mask;
        @(posedge clk_sys) disable iff (sys_rst)
        srcSel_r[POS_IRQ_MASK] && $past(srcSel_r[POS_IRQ_MASK]) |-> !dataIrq_r;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq fired");

    property p_irq_pass;
        @(posedge clk_sys) disable iff (sys_rst)
        dataReady && !srcSel_r[POS_IRQ_MASK] |=> dataIrq_r;
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq lost");

    property p_src_cic2;
        @(posedge clk_sys) disable iff (sys_rst)
        srcField == SRC_CIC2 |-> selWord == WIDTH'(taps.cic2);
    endproperty
    a_src_cic2: assert property (p_src_cic2) else $error("bad source");

    property p_flt_fir;
        @(posedge clk_sys) disable iff (sys_rst)
        !fltMa && srcField == SRC_FINAL |-> selWord == WIDTH'(taps.fir);
    endproperty
    a_flt_fir: assert property (p_flt_fir) else $error("fir not chosen");

    property p_avg_bypass;
        @(posedge clk_sys) disable iff (sys_rst)
        avgSel == AVG_BYPASS && tapValid && fifoInReady |=> avgOut_r == $past(taps.fir);
    endproperty
    a_avg_bypass: assert property (p_avg_bypass) else $error("bypass broken");

    property p_ro_write;
        @(posedge clk_sys) disable iff (sys_rst)
        regReq.wr && inRo |=> $stable(srcSel_r) && $stable(fltCtl_r);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("ro write took");

    property p_reserved;
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 (srcSel_r & ~WMASK_SRC_SEL) == 8'h00 && (fltCtl_r & ~WMASK_FLT_CTL) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved set");

    property p_wr_src;
        @(posedge clk_sys) disable iff (sys_rst)
        regReq.wr && regReq.addr == ADDR_SRC_SEL |=> srcSel_r == ($past(regReq.wdata) & WMASK_SRC_SEL);
    endproperty
    a_wr_src: assert property (p_wr_src) else $error("write lost");
endmodule

// ---- bench/vcf_host_model.sv ----
// host model driving the register request port of the block
module vcf_host_model (
    input  wire logic              clk_sys,
    output vcf_pkg::vcf_req_t      regReq,
    input  wire logic        [7:0] regRdata_r,
    input  wire logic              regRvalid_r
);
    timeunit 1ns;
    timeprecision 1ns;
    import vcf_pkg::*;
    // idle request at time zero
    initial begin
        regReq = '0;
    end
    // one write strobe, fields scrambled after release
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one read strobe, data taken while the one-cycle valid stands
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys);
        regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        v = regRvalid_r;
        d = regRdata_r;
        regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask
endmodule

// ---- bench/tb_vcf_select.sv ----
// self-checking bench for the voltage output filter select block
module tb_vcf_select;
    timeunit 1ns;
    timeprecision 1ns;
    import vcf_pkg::*;
    typedef struct {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} vcf_row_t;
    logic        clk_sys;
    logic        sys_rst;
    logic        tapValid;
    logic        dataReady;
    logic        outReady;
    vcf_req_t    regReq;
    vcf_taps_t   taps;
    logic [7:0]  regRdata_r;
    logic        regRvalid_r;
    logic        dataIrq_r;
    logic        outValid_r;
    logic        tapReady_r;
    logic [15:0] outWord_r;
    int          errors;
    int          n_tests;
    int          k;
    logic [15:0] seen[$];
    logic [15:0] xr[4] = '{16'h0000, 16'h2222, 16'h4444, 16'h8888};
    logic [3:0]  cnt[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
    // write address, data, read address, expected read value
    vcf_row_t    rows[7] = '{'{8'h46, 8'hFF, 8'h46, 8'h1C}, '{8'h47, 8'hFF, 8'h47, 8'hF8},
        '{8'h19, 8'h55, 8'h19, 8'h00}, '{8'h2C, 8'hAA, 8'h47, 8'hF8},
        '{8'h50, 8'hFF, 8'h50, 8'h00}, '{8'h46, 8'h00, 8'h46, 8'h00},
        '{8'h47, 8'h00, 8'h47, 8'h00}};

    vcf_select #(.WIDTH(16), .DEPTH(4)) vcf_select_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .regReq(regReq), .regRdata_r(regRdata_r), .regRvalid_r(regRvalid_r), .taps(taps),
        .tapValid(tapValid), .dataReady(dataReady), .dataIrq_r(dataIrq_r),
        .outWord_r(outWord_r), .outValid_r(outValid_r), .outReady(outReady),
        .tapReady_r(tapReady_r));
    vcf_host_model vcf_host_model_inst (.clk_sys(clk_sys), .regReq(regReq),
        .regRdata_r(regRdata_r), .regRvalid_r(regRvalid_r));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, 20 ns period
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // record every word taken by the sink
    always @(posedge clk_sys) begin
        if (outValid_r === 1'b1 && outReady === 1'b1) seen.push_back(outWord_r);
    end
    // hang guard
    initial begin
        repeat (4000) @(posedge clk_sys);
        errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        n_tests++;
        if (got !== ex) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // read one register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] d;
        logic       v;
        vcf_host_model_inst.rd_reg(a, d, v);
        chk("rvalid", 16'h0001, {15'h0, v});
        chk("rdata", {8'h00, ex}, {8'h00, d});
    endtask
    // one sample strobe, stage words derived from the fir word
    task automatic push(input logic [15:0] f);
        @(negedge clk_sys);
        taps = '{fir: f, cic2: f ^ 16'h2222, dechop: f ^ 16'h4444, cic1: f ^ 16'h8888};
        tapValid = 1'b1;
        @(negedge clk_sys);
        tapValid = 1'b0;
        taps = ~taps;
    endtask
    task automatic end_sim();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        tapValid = 1'b0;
        dataReady = 1'b0;
        outReady = 1'b1;
        taps = '0;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("outValid", 16'h0000, {15'h0, outValid_r});
        rchk(ADDR_SRC_SEL, 8'h04);
        rchk(ADDR_FLT_CTL, 8'h00);
        // register table rows
        foreach (rows[i]) begin
            vcf_host_model_inst.wr_reg(rows[i].wa, rows[i].wd);
            rchk(rows[i].ra, rows[i].ex);
        end
        // interrupt unmasked then masked
        for (int m = 0; m < 2; m++) begin
            vcf_host_model_inst.wr_reg(ADDR_SRC_SEL, m ? 8'h10 : 8'h00);
            @(negedge clk_sys);
            dataReady = 1'b1;
            @(negedge clk_sys);
            dataReady = 1'b0;
            chk("irq", m ? 16'h0 : 16'h1, {15'h0, dataIrq_r});
            @(negedge clk_sys);
            chk("irq idle", 16'h0000, {15'h0, dataIrq_r});
        end
        // moving average with each count, constant input gives itself
        foreach (cnt[c]) begin
            vcf_host_model_inst.wr_reg(ADDR_FLT_CTL, {1'b1, cnt[c], 3'b000});
            repeat (2 * int'(cnt[c]) + 2) push(16'h0A00 + 16'(c));
            repeat (8) @(negedge clk_sys);
            chk("average", 16'h0A00 + 16'(c), seen[$]);
        end
        // spread samples: 3, 6, 9 average to 6, seen one sample later
        vcf_host_model_inst.wr_reg(ADDR_FLT_CTL, 8'h80);
        push(16'h0000);
        vcf_host_model_inst.wr_reg(ADDR_FLT_CTL, 8'h98);
        for (int i = 1; i <= 4; i++) push(16'(3 * (i % 4)));
        repeat (8) @(negedge clk_sys);
        chk("spread average", 16'h0006, seen[$]);
        vcf_host_model_inst.wr_reg(ADDR_FLT_CTL, 8'h00);
        // each output source code
        for (int s = 0; s < 4; s++) begin
            vcf_host_model_inst.wr_reg(ADDR_SRC_SEL, 8'(s << 2));
            push(16'h1357 + 16'(s));
            repeat (6) @(negedge clk_sys);
            chk("source", (16'h1357 + 16'(s)) ^ xr[s], seen[$]);
        end
        // fill the buffer with the sink stalled, then drain it
        vcf_host_model_inst.wr_reg(ADDR_SRC_SEL, 8'h00);
        outReady = 1'b0;
        seen.delete();
        k = 0;
        repeat (8) if (tapReady_r === 1'b1) begin
            push(16'h5000 + 16'(k));
            k++;
        end
        repeat (2) @(negedge clk_sys);
        chk("tapReady full", 16'h0000, {15'h0, tapReady_r});
        outReady = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk("drained", 16'h0001, {15'h0, seen.size() == 5});
        for (int i = 0; i < 4; i++) chk("order", 16'h5000 + 16'(i), seen[i]);
        // reset in mid-run restores defaults and drops a held word
        vcf_host_model_inst.wr_reg(ADDR_SRC_SEL, 8'h1C);
        vcf_host_model_inst.wr_reg(ADDR_FLT_CTL, 8'hF8);
        outReady = 1'b0;
        push(16'h7777);
        repeat (2) @(negedge clk_sys);
        chk("outValid held", 16'h0001, {15'h0, outValid_r});
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("outValid reset", 16'h0000, {15'h0, outValid_r});
        outReady = 1'b1;
        rchk(ADDR_SRC_SEL, RST_SRC_SEL);
        rchk(ADDR_FLT_CTL, RST_FLT_CTL);
        end_sim();
    end
endmodule
